// ===== verilog/dsg_pkg.sv
// Purpose: constants for the deep-sleep peripheral clock gating block
// Assumes: 32-bit register port, one clock at 100 MHz
// Notes: offsets are byte addresses within the system control block
package dsg_pkg;

    localparam int unsigned data_w = 32;
    localparam int unsigned addr_w = 12;
    localparam int unsigned unit_n = 6;

    // register byte offsets
    localparam logic [11:0] run_gate_off = 12'h104;
    localparam logic [11:0] sleep_gate_off = 12'h114;
    localparam logic [11:0] deep_sleep_gate_off = 12'h124;
    localparam logic [11:0] run_clock_config_off = 12'h060;
    localparam logic [11:0] irq_status_off = 12'h150;
    localparam logic [11:0] irq_mask_off = 12'h154;
    localparam logic [11:0] fault_unit_off = 12'h158;

    // gating bit positions
    localparam int unsigned comparator_bit = 24;
    localparam int unsigned timer_b_bit = 17;
    localparam int unsigned timer_a_bit = 16;
    localparam int unsigned two_wire_bit = 12;
    localparam int unsigned sync_serial_bit = 4;
    localparam int unsigned async_serial_bit = 0;
    localparam int unsigned auto_gate_bit = 27;

    // writable bits of each gating register; the rest read zero
    localparam logic [31:0] gate_mask = 32'h0103_1011;
    localparam logic [31:0] run_clock_config_mask = 32'h0800_0000;
    localparam logic [31:0] gate_reset = 32'h0000_0000;
    localparam logic [31:0] config_reset = 32'h0000_0000;

    // interrupt status layout
    localparam int unsigned irq_fault_bit = 0;
    localparam int unsigned irq_unmapped_bit = 1;
    localparam logic [31:0] irq_bits_mask = 32'h0000_0003;

    // unit index to gating bit position
    localparam int unsigned unit_bit [unit_n] = '{0, 4, 12, 16, 17, 24};

    typedef enum logic [1:0] {
        dsg_run_t_run = 2'b00,
        dsg_run_t_sleep = 2'b01,
        dsg_run_t_deep = 2'b10
    } dsg_power_t;

endpackage

// ===== verilog/dsg_unit_gate.sv
// Purpose: per-unit clock gate and access fault check
// Assumes: enable changes only at rising clock edges
// Notes: latch-based gate keeps the gated clock free of glitches
`timescale 1ns/1ps
module dsg_unit_gate (
    input wire logic clock,
    input wire logic enable,
    input wire logic access,
    output logic unit_clock,
    output logic fault
);
    logic enable_latched;

    // latch follows enable while the clock is low, so a change cannot cut a high phase
    always_latch begin
        if (!clock) begin
            enable_latched <= enable;
        end
    end

    assign unit_clock = clock & enable_latched;
    assign fault = access & ~enable;
endmodule // dsg_unit_gate

// ===== verilog/dsg_clock_gate.sv
// Purpose: peripheral clock gating registers with per-unit gated clocks
// Assumes: power_state comes from the power sequencer, synchronous to clock
// Notes: status bits are sticky, cleared by writing one
`timescale 1ns/1ps
module dsg_clock_gate (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic [1:0] power_state,
    input wire logic [5:0] unit_access,
    output logic [5:0] unit_clock,
    output logic [5:0] unit_enable,
    output logic bus_fault,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [31:0] run_gate_reg;
    logic [31:0] sleep_gate_reg;
    logic [31:0] deep_sleep_gate_reg;
    logic [31:0] run_clock_config;
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    logic [5:0] fault_unit;
    logic auto_gate_select;
    logic [5:0] unit_fault;
    logic any_fault;
    logic hit;
    logic sel_run_gate;
    logic sel_sleep_gate;
    logic sel_deep_gate;
    logic sel_config;
    logic sel_status;
    logic sel_mask;
    logic sel_fault_unit;
    logic wr_run_gate;
    logic wr_sleep_gate;
    logic wr_deep_gate;
    logic wr_config;
    logic wr_status;
    logic wr_mask;
    logic unmapped_access;
    logic [31:0] status_clear;
    logic [31:0] status_set;
    logic [31:0] next_irq_status;
    logic [31:0] next_rdata;
    logic comparator_gate;
    logic timer_b_gate;
    logic timer_a_gate;
    logic two_wire_gate;
    logic sync_serial_gate;
    logic async_serial_gate;
    logic [5:0] run_units;
    logic [5:0] sleep_units;
    logic [5:0] deep_sleep_units;
    logic [5:0] state_units;

    assign auto_gate_select = run_clock_config[dsg_pkg::auto_gate_bit];

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    // one compare per register, shared by the write strobes and the unmapped check
    assign sel_run_gate = addr == dsg_pkg::run_gate_off;
    assign sel_sleep_gate = addr == dsg_pkg::sleep_gate_off;
    assign sel_deep_gate = addr == dsg_pkg::deep_sleep_gate_off;
    assign sel_config = addr == dsg_pkg::run_clock_config_off;
    assign sel_status = addr == dsg_pkg::irq_status_off;
    assign sel_mask = addr == dsg_pkg::irq_mask_off;
    assign sel_fault_unit = addr == dsg_pkg::fault_unit_off;

    assign wr_run_gate = wr_en && sel_run_gate;
    assign wr_sleep_gate = wr_en && sel_sleep_gate;
    assign wr_deep_gate = wr_en && sel_deep_gate;
    assign wr_config = wr_en && sel_config;
    assign wr_status = wr_en && sel_status;
    assign wr_mask = wr_en && sel_mask;

    // the fault unit register is read-only: a write to it is mapped but changes nothing
    assign hit = sel_run_gate || sel_sleep_gate || sel_deep_gate || sel_config || sel_status || sel_mask ||
        sel_fault_unit;
    assign unmapped_access = (wr_en || rd_en) && !hit;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            run_gate_reg <= dsg_pkg::gate_reset;
        end else if (wr_run_gate) begin
            run_gate_reg <= wdata & dsg_pkg::gate_mask;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sleep_gate_reg <= dsg_pkg::gate_reset;
        end else if (wr_sleep_gate) begin
            sleep_gate_reg <= wdata & dsg_pkg::gate_mask;
        end
    end

    // mask keeps only bits 24, 17, 16, 12, 4 and 0 writable
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            deep_sleep_gate_reg <= dsg_pkg::gate_reset;
        end else if (wr_deep_gate) begin
            deep_sleep_gate_reg <= wdata & dsg_pkg::gate_mask;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            run_clock_config <= dsg_pkg::config_reset;
        end else if (wr_config) begin
            run_clock_config <= wdata & dsg_pkg::run_clock_config_mask;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask <= dsg_pkg::gate_reset;
        end else if (wr_mask) begin
            irq_mask <= wdata & dsg_pkg::irq_bits_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gate selection

    // named views of the deep-sleep fields, packed below in unit index order
    assign comparator_gate = deep_sleep_gate_reg[dsg_pkg::comparator_bit];
    assign timer_b_gate = deep_sleep_gate_reg[dsg_pkg::timer_b_bit];
    assign timer_a_gate = deep_sleep_gate_reg[dsg_pkg::timer_a_bit];
    assign two_wire_gate = deep_sleep_gate_reg[dsg_pkg::two_wire_bit];
    assign sync_serial_gate = deep_sleep_gate_reg[dsg_pkg::sync_serial_bit];
    assign async_serial_gate = deep_sleep_gate_reg[dsg_pkg::async_serial_bit];
    assign deep_sleep_units = {comparator_gate, timer_b_gate, timer_a_gate, two_wire_gate, sync_serial_gate,
        async_serial_gate};

    // power_state 3 is not a real state and falls back to the run set
    always_comb begin
        state_units = run_units;
        if (auto_gate_select) begin
            case (power_state)
                2'b00: state_units = run_units;
                2'b01: state_units = sleep_units;
                2'b10: state_units = deep_sleep_units;
                default: state_units = run_units;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < dsg_pkg::unit_n; gi = gi + 1) begin : g_unit
            assign run_units[gi] = run_gate_reg[dsg_pkg::unit_bit[gi]];
            assign sleep_units[gi] = sleep_gate_reg[dsg_pkg::unit_bit[gi]];
            assign unit_enable[gi] = state_units[gi];
            dsg_unit_gate u_gate (
                .clock(clock),
                .enable(unit_enable[gi]),
                .access(unit_access[gi]),
                .unit_clock(unit_clock[gi]),
                .fault(unit_fault[gi])
            );
        end
    endgenerate

    assign any_fault = |unit_fault;
    // combinational so the fault answers in the same cycle as the access
    assign bus_fault = any_fault;

    ////////////////////////////////////////////////////////////////////////////
    // events and interrupt

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fault_unit <= 6'h0;
        end else if (any_fault) begin
            fault_unit <= unit_fault;
        end
    end

    assign status_clear = wr_status ? (wdata & dsg_pkg::irq_bits_mask) : 32'h0000_0000;

    always_comb begin
        status_set = 32'h0000_0000;
        status_set[dsg_pkg::irq_fault_bit] = any_fault;
        status_set[dsg_pkg::irq_unmapped_bit] = unmapped_access;
    end

    // set wins over a same-cycle write-one clear, so an event landing during the clear is kept
    assign next_irq_status = (irq_status & ~status_clear) | status_set;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= 32'h0000_0000;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // read port

    // zero outside the answer cycle, so read data from several slaves can be ored together
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd_en) begin
            case (addr)
                dsg_pkg::run_gate_off: next_rdata = run_gate_reg;
                dsg_pkg::sleep_gate_off: next_rdata = sleep_gate_reg;
                dsg_pkg::deep_sleep_gate_off: next_rdata = deep_sleep_gate_reg;
                dsg_pkg::run_clock_config_off: next_rdata = run_clock_config;
                dsg_pkg::irq_status_off: next_rdata = irq_status;
                dsg_pkg::irq_mask_off: next_rdata = irq_mask;
                dsg_pkg::fault_unit_off: next_rdata = {26'h0, fault_unit};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule // dsg_clock_gate

// ===== bench/dsg_clock_gate_properties.sv
// Purpose: port assertions for the clock gating block
// Assumes: one clock, async active-low reset
// Notes: unit_clock moves between edges, so the bench judges it
`timescale 1ns/1ps
module dsg_clock_gate_checker (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic [1:0] power_state,
    input wire logic [5:0] unit_access,
    input wire logic [5:0] unit_clock,
    input wire logic [5:0] unit_enable,
    input wire logic bus_fault,
    input wire logic irq
);
    localparam logic [11:0] dso = dsg_pkg::deep_sleep_gate_off;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    chk_fault_gated: assert property (bus_fault == |(unit_access & ~unit_enable))
        else $error("fault mismatch");
    chk_reset_clear: assert property ($rose(arst_n) |-> unit_enable == 6'h00 && rdata == 32'h0000_0000)
        else $error("not clear after reset");
    chk_gate_reserved: assert property (rd_en && addr == dso |=> (rdata & ~dsg_pkg::gate_mask) == 32'h0000_0000)
        else $error("reserved bit set");
    chk_write_read: assert property (wr_en && addr == dso ##1 rd_en && addr == dso |=>
        rdata == ($past(wdata, 2) & dsg_pkg::gate_mask))
        else $error("readback mismatch");
    chk_rdata_idle: assert property (!rd_en |=> rdata == 32'h0000_0000)
        else $error("rdata not idle");
    chk_unmapped_zero: assert property (rd_en && addr == 12'h200 |=> rdata == 32'h0000_0000)
        else $error("unmapped read nonzero");
    // enables may only move after a write or a power state change
    chk_enable_hold: assert property (!$past(wr_en) && $stable(power_state) |-> $stable(unit_enable))
        else $error("enable moved");
    chk_fault_sticky: assert property (bus_fault ##1 rd_en && addr == dsg_pkg::irq_status_off |=> rdata[0])
        else $error("fault not recorded");
endmodule // dsg_clock_gate_checker
bind dsg_clock_gate dsg_clock_gate_checker dsg_clock_gate_checker_inst (.*);

// ===== bench/dsg_clock_gate_tb.sv
// Purpose: register, selection and fault tests for the clock gating block
// Assumes: read data one cycle after the read strobe
// Notes: unit_clock sampled inside the high and low phases
`timescale 1ns/1ps
module dsg_clock_gate_tb;
    logic clock = 0, arst_n = 0, wr_en = 0, rd_en = 0, bus_fault, irq;
    logic [11:0] addr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] power_state = 0;
    logic [5:0] unit_access = 0, unit_clock, unit_enable;
    int mismatches = 0, samples_checked = 0;
    int pos [6] = '{0, 4, 12, 16, 17, 24};
    localparam logic [11:0] dso = dsg_pkg::deep_sleep_gate_off;
    localparam logic [11:0] sto = dsg_pkg::irq_status_off;
    dsg_clock_gate dsg_clock_gate_inst (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .power_state(power_state), .unit_access(unit_access), .unit_clock(unit_clock),
        .unit_enable(unit_enable), .bus_fault(bus_fault), .irq(irq));
    initial forever #5 clock = ~clock;
    ////////////////////////////////////////
    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // write strobe stays up until the next access or idle, so writes may run back to back
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 cmp("rdata", exp, rdata);
    endtask
    task idle();
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task close_out();
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (1000) @(posedge clock);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        rd(dso, 32'h0000_0000);
        rd(dsg_pkg::run_gate_off, 32'h0000_0000);
        rd(dsg_pkg::sleep_gate_off, 32'h0000_0000);
        wr(dso, 32'hffff_ffff);
        rd(dso, 32'h0103_1011);
        wr(dsg_pkg::run_clock_config_off, 32'h0800_0000);
        idle();
        @(posedge clock) power_state <= 2'd2;
        for (int i = 0; i < 6; i++) begin
            wr(dso, 32'h0000_0001 << pos[i]);
            idle();
            #1 cmp("unit_enable", 32'h0000_0001 << i, 32'(unit_enable));
        end
        @(posedge clock) power_state <= 2'd1;
        #1 cmp("unit_enable", 32'h0000_0000, 32'(unit_enable));
        wr(dsg_pkg::run_gate_off, 32'hffff_ffff);
        wr(dsg_pkg::run_clock_config_off, 32'h0000_0000);
        idle();
        #1 cmp("unit_enable", 32'h0000_003f, 32'(unit_enable));
        @(posedge clock) #2 cmp("unit_clock", 32'h0000_003f, 32'(unit_clock));
        #5 cmp("unit_clock", 32'h0000_0000, 32'(unit_clock));
        wr(dsg_pkg::run_gate_off, 32'h0000_0000);
        wr(dsg_pkg::irq_mask_off, 32'h0000_0001);
        @(posedge clock) begin
            wr_en <= 1'b0;
            unit_access <= 6'h20;
        end
        #1 cmp("bus_fault", 32'h0000_0001, 32'(bus_fault));
        // status read right behind the fault, so the sticky-bit property sees its trigger
        @(posedge clock) begin
            unit_access <= 6'h00;
            rd_en <= 1'b1;
            addr <= sto;
        end
        #1 cmp("irq", 32'h0000_0001, 32'(irq));
        @(posedge clock) rd_en <= 1'b0;
        #1 cmp("rdata", 32'h0000_0001, rdata);
        rd(dsg_pkg::fault_unit_off, 32'h0000_0020);
        wr(sto, 32'h0000_0001);
        rd(12'h200, 32'h0000_0000);
        cmp("irq", 32'h0000_0000, 32'(irq));
        rd(sto, 32'h0000_0002);
        close_out();
    end
endmodule // dsg_clock_gate_tb
